// *** rtl/cob_pkg.sv ***
// Constants, encodings and types shared by the core and its address unit.
// Assumes a single 10 MHz clock and synchronous, active-low reset.
// Operation
// - Fixed 16-bit instructions, mostly one cycle each
// - Register arithmetic and logic on 32-bit values, bit operations on a byte
// - Byte and word loads are sign-extended
// - Move, add, compare immediates sign-extended
// - Test, and, or, xor immediates zero-extended
// - Ordinary operations use register operands only
// - Bit and, or, xor read-modify-write memory directly; bit test only reads
// - Unconditional jumps are always delayed
// - Slot instruction runs before the target
// - Conditional jumps come delayed and normal
// - Compares write one flag, t_ff (cmp_flag)
// - Conditional jumps test the compare flag
// - Only compares and tests change the flag
// - Register add leaves the flag alone
// - Byte literal sits in the instruction word
// - Wider literals load PC-relative from memory
// - Register direct uses the register contents
// - Register indirect addresses by unchanged register
// - Post-increment adds 1, 2 or 4 after
// - Pre-decrement subtracts 1, 2 or 4 first
// - Misaligned word or longword raises address error
package cob_pkg;
    localparam logic [31:0] COB_PC_RESET = 32'ha0000000;
    localparam logic [31:0] COB_PC_STEP = 32'h2;
    localparam logic [31:0] COB_BR_BIAS = 32'h4;
    localparam logic [31:0] COB_STEP_B = 32'h1;
    localparam logic [31:0] COB_STEP_W = 32'h2;
    localparam logic [31:0] COB_STEP_L = 32'h4;
    localparam logic [0:0] COB_T_RESET = 1'h0;

    // Major opcodes, instruction bits 15:12
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_MOVI = 4'h1;
    localparam logic [3:0] OP_ADDI = 4'h2;
    localparam logic [3:0] OP_CMPI = 4'h3;
    localparam logic [3:0] OP_ALU = 4'h4;
    localparam logic [3:0] OP_LOGI = 4'h5;
    localparam logic [3:0] OP_LD = 4'h6;
    localparam logic [3:0] OP_ST = 4'h7;
    localparam logic [3:0] OP_LITW = 4'h8;
    localparam logic [3:0] OP_LITL = 4'h9;
    localparam logic [3:0] OP_JMP = 4'ha;
    localparam logic [3:0] OP_JCC = 4'hb;
    localparam logic [3:0] OP_BIT = 4'hc;

    // Register-register functions, bits 3:0
    localparam logic [3:0] FN_ADD = 4'h0;
    localparam logic [3:0] FN_AND = 4'h1;
    localparam logic [3:0] FN_OR = 4'h2;
    localparam logic [3:0] FN_XOR = 4'h3;
    localparam logic [3:0] FN_CMPEQ = 4'h4;
    localparam logic [3:0] FN_TST = 4'h5;
    localparam logic [3:0] FN_MOV = 4'h6;

    // Logical-immediate and bit functions, bits 11:10
    localparam logic [1:0] LF_TST = 2'h0;
    localparam logic [1:0] LF_AND = 2'h1;
    localparam logic [1:0] LF_OR = 2'h2;
    localparam logic [1:0] LF_XOR = 2'h3;

    localparam logic [1:0] SZ_B = 2'h0;
    localparam logic [1:0] SZ_W = 2'h1;
    localparam logic [1:0] SZ_L = 2'h2;
    localparam logic [1:0] MD_IND = 2'h0;
    localparam logic [1:0] MD_POST = 2'h1;
    localparam logic [1:0] MD_PRE = 2'h2;

    typedef enum logic [1:0] {cob_run, cob_load, cob_rmw, cob_wr} cob_state_t;
endpackage

// *** rtl/cob_agu.sv ***
// Effective address unit for the register indirect modes.
// Purely combinational; the core writes back the updated base itself.
`timescale 1ns/10ps
module cob_agu import cob_pkg::*; (
    input wire logic [31:0] base,
    input wire logic [1:0] size,
    input wire logic [1:0] mode,
    output logic [31:0] ea,
    output logic [31:0] upd,
    output logic upd_en,
    output logic misal
);
    logic [31:0] step;

    always_comb begin
        step = (size == SZ_B) ? COB_STEP_B : (size == SZ_W) ? COB_STEP_W : COB_STEP_L;
        ea = (mode == MD_PRE) ? base - step : base;
        upd = (mode == MD_POST) ? base + step : base - step;
        upd_en = (mode == MD_POST) || (mode == MD_PRE);
        misal = ((size == SZ_W) && ea[0]) || ((size == SZ_L) && (ea[1:0] != 2'h0));
    end
endmodule // cob_agu

// *** rtl/cob_core.sv ***
// Execution core: decode of 16-bit instructions, register file, flag,
// delayed branching and data memory sequencing.
// Assumes instruction memory answers combinationally on imem_addr and data
// memory answers combinationally while dmem_req is high.
`timescale 1ns/10ps
module cob_core import cob_pkg::*; #(
    parameter logic [31:0] RESET_PC = COB_PC_RESET
) (
    input wire logic clk_sys,
    input wire logic rstn,
    output logic [31:0] imem_addr,
    input wire logic [15:0] imem_rdata,
    output logic dmem_req,
    output logic dmem_we,
    output logic [1:0] dmem_size,
    output logic [31:0] dmem_addr,
    output logic [31:0] dmem_wdata,
    input wire logic [31:0] dmem_rdata,
    output logic addr_err,
    output logic cmp_flag,
    output logic retire
);
    cob_state_t st_ff, nxt_st;
    logic [31:0] pc_ff, nxt_pc, tgt_ff, nxt_tgt;
    logic slot_ff, nxt_slot, t_ff, nxt_t;
    logic req_ff, nxt_req, we_ff, nxt_we, err_ff, nxt_err, ret_ff, nxt_ret;
    logic [1:0] sz_ff, nxt_sz;
    logic [31:0] addr_ff, nxt_addr, wdat_ff, nxt_wdat;
    logic [3:0] ld_idx_ff, nxt_ld_idx;
    logic [1:0] bfn_ff, nxt_bfn;
    logic [7:0] bimm_ff, nxt_bimm;
    logic [31:0] gpr_ff [16];

    logic wa_en, wb_en;
    logic [3:0] wa_idx, wb_idx;
    logic [31:0] wa_dat, wb_dat;

    logic [3:0] f_op, f_rn, f_rm, f_fn;
    logic [7:0] f_imm;
    logic [1:0] f_lf;
    logic [31:0] rv_n, rv_m, rv_0, imm_s, imm_z, jcc_tgt;
    logic [31:0] agu_base, ea, upd;
    logic [1:0] agu_sz, agu_md;
    logic upd_en, misal, jcc_take;
    logic [7:0] bit_res;

    function automatic logic [31:0] ext_ld(input logic [31:0] d, input logic [1:0] sz);
        ext_ld = (sz == SZ_B) ? {{24{d[7]}}, d[7:0]} :
            (sz == SZ_W) ? {{16{d[15]}}, d[15:0]} : d;
    endfunction

    // Decode fields
    always_comb begin
        f_op = imem_rdata[15:12];
        f_rn = imem_rdata[11:8];
        f_rm = imem_rdata[7:4];
        f_fn = imem_rdata[3:0];
        f_imm = imem_rdata[7:0];
        f_lf = imem_rdata[11:10];
        rv_n = gpr_ff[f_rn];
        rv_m = gpr_ff[f_rm];
        rv_0 = gpr_ff[0];
        imm_s = {{24{f_imm[7]}}, f_imm};
        imm_z = {24'h0, f_imm};
        jcc_tgt = pc_ff + COB_BR_BIAS + {{23{f_imm[7]}}, f_imm, 1'b0};
        jcc_take = imem_rdata[10] ? !t_ff : t_ff;
        agu_base = (f_op == OP_LD) ? rv_m : (f_op == OP_ST) ? rv_n : rv_0;
        agu_sz = (f_op == OP_BIT) ? SZ_B : imem_rdata[3:2];
        agu_md = (f_op == OP_BIT) ? MD_IND : imem_rdata[1:0];
    end

    cob_agu u_agu (
        .base(agu_base),
        .size(agu_sz),
        .mode(agu_md),
        .ea(ea),
        .upd(upd),
        .upd_en(upd_en),
        .misal(misal)
    );

    // Byte result of a memory bit operation
    always_comb begin
        case (bfn_ff)
            LF_AND: bit_res = dmem_rdata[7:0] & bimm_ff;
            LF_OR: bit_res = dmem_rdata[7:0] | bimm_ff;
            LF_XOR: bit_res = dmem_rdata[7:0] ^ bimm_ff;
            default: bit_res = dmem_rdata[7:0];
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_pc = pc_ff;
        nxt_tgt = tgt_ff;
        nxt_slot = slot_ff;
        nxt_t = t_ff;
        nxt_req = 1'b0;
        nxt_we = 1'b0;
        nxt_err = 1'b0;
        nxt_ret = 1'b0;
        nxt_sz = sz_ff;
        nxt_addr = addr_ff;
        nxt_wdat = wdat_ff;
        nxt_ld_idx = ld_idx_ff;
        nxt_bfn = bfn_ff;
        nxt_bimm = bimm_ff;
        wa_en = 1'b0;
        wa_idx = f_rn;
        wa_dat = 32'h0;
        wb_en = 1'b0;
        wb_idx = f_rm;
        wb_dat = upd;
        case (st_ff)
            cob_run: begin
                nxt_ret = 1'b1;
                nxt_pc = pc_ff + COB_PC_STEP;
                if (slot_ff) begin
                    // Slot issues now (a load or bit operation finishes in later states); go to the target
                    nxt_pc = tgt_ff;
                    nxt_slot = 1'b0;
                end
                case (f_op)
                    OP_MOVI: begin
                        wa_en = 1'b1;
                        wa_dat = imm_s;
                    end
                    OP_ADDI: begin
                        wa_en = 1'b1;
                        wa_dat = rv_n + imm_s;
                    end
                    OP_CMPI: nxt_t = (rv_n == imm_s);
                    OP_ALU: begin
                        wa_en = 1'b1;
                        case (f_fn)
                            FN_ADD: wa_dat = rv_n + rv_m;
                            FN_AND: wa_dat = rv_n & rv_m;
                            FN_OR: wa_dat = rv_n | rv_m;
                            FN_XOR: wa_dat = rv_n ^ rv_m;
                            FN_MOV: wa_dat = rv_m;
                            FN_CMPEQ: begin
                                wa_en = 1'b0;
                                nxt_t = (rv_n == rv_m);
                            end
                            FN_TST: begin
                                wa_en = 1'b0;
                                nxt_t = ((rv_n & rv_m) == 32'h0);
                            end
                            default: wa_en = 1'b0;
                        endcase
                    end
                    OP_LOGI: begin
                        wa_idx = 4'h0;
                        wa_en = 1'b1;
                        case (f_lf)
                            LF_AND: wa_dat = rv_0 & imm_z;
                            LF_OR: wa_dat = rv_0 | imm_z;
                            LF_XOR: wa_dat = rv_0 ^ imm_z;
                            default: begin
                                wa_en = 1'b0;
                                nxt_t = ((rv_0 & imm_z) == 32'h0);
                            end
                        endcase
                    end
                    OP_LD, OP_ST: begin
                        if (misal) begin
                            nxt_err = 1'b1;
                        end else begin
                            nxt_req = 1'b1;
                            nxt_we = (f_op == OP_ST);
                            nxt_addr = ea;
                            nxt_sz = agu_sz;
                            nxt_wdat = rv_m;
                            nxt_ld_idx = f_rn;
                            wb_en = upd_en;
                            wb_idx = (f_op == OP_LD) ? f_rm : f_rn;
                            if (f_op == OP_LD) begin
                                nxt_st = cob_load;
                            end
                        end
                    end
                    OP_LITW, OP_LITL: begin
                        nxt_req = 1'b1;
                        nxt_ld_idx = f_rn;
                        nxt_sz = (f_op == OP_LITW) ? SZ_W : SZ_L;
                        nxt_addr = (f_op == OP_LITW) ?
                            pc_ff + COB_BR_BIAS + {23'h0, f_imm, 1'b0} :
                            {pc_ff[31:2], 2'h0} + COB_BR_BIAS + {22'h0, f_imm, 2'h0};
                        nxt_st = cob_load;
                    end
                    OP_JMP: begin
                        // A jump in a slot is ignored
                        if (!slot_ff) begin
                            nxt_slot = 1'b1;
                            nxt_tgt = pc_ff + COB_BR_BIAS +
                                {{19{imem_rdata[11]}}, imem_rdata[11:0], 1'b0};
                        end
                    end
                    OP_JCC: begin
                        if (!slot_ff && jcc_take) begin
                            if (imem_rdata[11]) begin
                                nxt_slot = 1'b1;
                                nxt_tgt = jcc_tgt;
                            end else begin
                                nxt_pc = jcc_tgt;
                            end
                        end
                    end
                    OP_BIT: begin
                        nxt_req = 1'b1;
                        nxt_addr = ea;
                        nxt_sz = SZ_B;
                        nxt_bfn = f_lf;
                        nxt_bimm = f_imm;
                        nxt_st = cob_rmw;
                    end
                    default: ;
                endcase
            end
            cob_load: begin
                wa_en = 1'b1;
                wa_idx = ld_idx_ff;
                wa_dat = ext_ld(dmem_rdata, sz_ff);
                nxt_st = cob_run;
            end
            cob_rmw: begin
                if (bfn_ff == LF_TST) begin
                    nxt_t = ((dmem_rdata[7:0] & bimm_ff) == 8'h0);
                    nxt_st = cob_run;
                end else begin
                    nxt_req = 1'b1;
                    nxt_we = 1'b1;
                    nxt_wdat = {24'h0, bit_res};
                    nxt_st = cob_wr;
                end
            end
            cob_wr: nxt_st = cob_run;
            default: nxt_st = cob_run;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_ff <= cob_run;
            pc_ff <= RESET_PC;
            tgt_ff <= 32'h0;
            slot_ff <= 1'b0;
            t_ff <= COB_T_RESET;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            err_ff <= 1'b0;
            ret_ff <= 1'b0;
            sz_ff <= SZ_B;
            addr_ff <= 32'h0;
            wdat_ff <= 32'h0;
            ld_idx_ff <= 4'h0;
            bfn_ff <= LF_TST;
            bimm_ff <= 8'h0;
        end else begin
            st_ff <= nxt_st;
            pc_ff <= nxt_pc;
            tgt_ff <= nxt_tgt;
            slot_ff <= nxt_slot;
            t_ff <= nxt_t;
            req_ff <= nxt_req;
            we_ff <= nxt_we;
            err_ff <= nxt_err;
            ret_ff <= nxt_ret;
            sz_ff <= nxt_sz;
            addr_ff <= nxt_addr;
            wdat_ff <= nxt_wdat;
            ld_idx_ff <= nxt_ld_idx;
            bfn_ff <= nxt_bfn;
            bimm_ff <= nxt_bimm;
        end
    end

    // Register file left unreset; the load port wins over a base update
    always_ff @(posedge clk_sys) begin
        if (rstn && wb_en) begin
            gpr_ff[wb_idx] <= wb_dat;
        end
        if (rstn && wa_en) begin
            gpr_ff[wa_idx] <= wa_dat;
        end
    end

    assign imem_addr = pc_ff;
    assign dmem_req = req_ff;
    assign dmem_we = we_ff;
    assign dmem_size = sz_ff;
    assign dmem_addr = addr_ff;
    assign dmem_wdata = wdat_ff;
    assign addr_err = err_ff;
    assign cmp_flag = t_ff;
    assign retire = ret_ff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic run_ok;
    assign run_ok = (st_ff == cob_run) && rstn; // No attempt from the last reset edge

    property p_fetch_even;
        imem_addr[0] == 1'b0;
    endproperty
    a_fetch_even: assert property (p_fetch_even) else $error("odd fetch address");

    property p_ld_sext_b;
        (st_ff == cob_load) && (sz_ff == SZ_B) |-> wa_dat[31:8] == {24{dmem_rdata[7]}};
    endproperty
    a_ld_sext_b: assert property (p_ld_sext_b) else $error("byte load not sign extended");

    property p_movi_sext;
        run_ok && (f_op == OP_MOVI) |=> gpr_ff[$past(f_rn)] == {{24{$past(f_imm[7])}}, $past(f_imm)};
    endproperty
    a_movi_sext: assert property (p_movi_sext) else $error("move immediate wrong");

    property p_and_zext;
        run_ok && (f_op == OP_LOGI) && (f_lf == LF_AND) |=> gpr_ff[0][31:8] == 24'h0;
    endproperty
    a_and_zext: assert property (p_and_zext) else $error("and immediate not zero extended");

    property p_jmp_slot;
        run_ok && (f_op == OP_JMP) && !slot_ff && (f_op != OP_LD)
            |=> slot_ff && (imem_addr == $past(pc_ff) + 32'h2);
    endproperty
    a_jmp_slot: assert property (p_jmp_slot) else $error("jump skipped its slot");

    property p_jcc_normal;
        run_ok && (f_op == OP_JCC) && !slot_ff && jcc_take && !imem_rdata[11]
            |=> !slot_ff && (pc_ff == $past(jcc_tgt));
    endproperty
    a_jcc_normal: assert property (p_jcc_normal) else $error("normal jump wrong target");

    property p_add_keeps_t;
        run_ok && (f_op == OP_ALU) && (f_fn == FN_ADD) |=> t_ff == $past(t_ff);
    endproperty
    a_add_keeps_t: assert property (p_add_keeps_t) else $error("add changed flag");

    property p_post_l;
        run_ok && (f_op == OP_LD) && (imem_rdata[3:0] == {SZ_L, MD_POST}) && !misal
            |=> gpr_ff[$past(f_rm)] == $past(rv_m) + 32'h4;
    endproperty
    a_post_l: assert property (p_post_l) else $error("post increment wrong");

    property p_pre_w;
        run_ok && (f_op == OP_ST) && (imem_rdata[3:0] == {SZ_W, MD_PRE}) && !misal
            |=> dmem_req && dmem_we && (dmem_addr == $past(rv_n) - 32'h2);
    endproperty
    a_pre_w: assert property (p_pre_w) else $error("pre decrement wrong");

    property p_misal_w;
        run_ok && (f_op == OP_LD) && (imem_rdata[3:0] == {SZ_W, MD_IND}) && rv_m[0]
            |=> addr_err && !dmem_req;
    endproperty
    a_misal_w: assert property (p_misal_w) else $error("no address error");

    property p_bit_rmw;
        run_ok && (f_op == OP_BIT) && (f_lf != LF_TST)
            |=> dmem_req && !dmem_we ##1 dmem_req && dmem_we;
    endproperty
    a_bit_rmw: assert property (p_bit_rmw) else $error("bit operation not read-modify-write");

    c_load: cover property (run_ok && (f_op == OP_LD) ##1 st_ff == cob_load);
    c_slot: cover property (run_ok && (f_op == OP_JMP) ##1 slot_ff ##1 !slot_ff);
    c_rmw: cover property (st_ff == cob_rmw ##1 st_ff == cob_wr);
endmodule // cob_core

// *** sim/cpu_operand_and_branch_semantics_test.sv ***
// Self-checking bench for the execution core: small programs, byte-wide data memory.
// Assumes combinational instruction and data memories; programs end in a self jump.
`timescale 1ns/10ps
module cpu_operand_and_branch_semantics_test import cob_pkg::*;;
    logic clk_sys;
    logic rstn;
    logic [31:0] imem_addr;
    logic [15:0] imem_rdata;
    logic dmem_req;
    logic dmem_we;
    logic [1:0] dmem_size;
    logic [31:0] dmem_addr;
    logic [31:0] dmem_wdata;
    logic [31:0] dmem_rdata;
    logic addr_err;
    logic cmp_flag;
    logic retire;
    logic [15:0] imem [0:63];
    logic [7:0] dmem_b [0:255];
    logic [7:0] da;
    logic [15:0] prog_q [$];
    int n_mismatch;
    int check_count;
    int n_err;
    int n_ret;

    cob_core #(.RESET_PC(32'h00000000)) DUT (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .imem_addr(imem_addr),
        .imem_rdata(imem_rdata),
        .dmem_req(dmem_req),
        .dmem_we(dmem_we),
        .dmem_size(dmem_size),
        .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata),
        .dmem_rdata(dmem_rdata),
        .addr_err(addr_err),
        .cmp_flag(cmp_flag),
        .retire(retire)
    );

    // Memories must answer in the same cycle, so these two are combinational
    assign imem_rdata = imem[imem_addr[6:1]];
    assign da = dmem_addr[7:0];
    // Full four bytes returned so that missing extension shows up
    assign dmem_rdata = {dmem_b[da + 8'h3], dmem_b[da + 8'h2], dmem_b[da + 8'h1], dmem_b[da]};

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (rstn && dmem_req === 1'b1 && dmem_we === 1'b1) begin
            dmem_b[da] <= dmem_wdata[7:0];
            if (dmem_size != SZ_B) begin
                dmem_b[da + 8'h1] <= dmem_wdata[15:8];
            end
            if (dmem_size == SZ_L) begin
                dmem_b[da + 8'h2] <= dmem_wdata[23:16];
                dmem_b[da + 8'h3] <= dmem_wdata[31:24];
            end
        end
        if (rstn && addr_err === 1'b1) begin
            n_err++;
        end
        if (rstn && retire === 1'b1) begin
            n_ret++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] word_at(input logic [7:0] a);
        return {dmem_b[a + 8'h3], dmem_b[a + 8'h2], dmem_b[a + 8'h1], dmem_b[a]};
    endfunction

    task automatic clear_mem();
        for (int i = 0; i < 256; i++) begin
            dmem_b[i] = 8'h00;
        end
    endtask

    // Loads prog_q, appends a self jump with a nop slot, resets and runs
    task automatic run_prog();
        @(posedge clk_sys);
        rstn <= 1'b0;
        // Program swapped only once the core is already held in reset
        @(posedge clk_sys);
        for (int i = 0; i < 64; i++) begin
            imem[i] = 16'h0000;
        end
        foreach (prog_q[i]) begin
            imem[i] = prog_q[i];
        end
        imem[prog_q.size()] = 16'haffe;
        repeat (11) @(posedge clk_sys);
        check("pc_in_reset", imem_addr, 32'h00000000);
        check("req_in_reset", {31'h0, dmem_req}, 32'h0);
        n_err = 0;
        n_ret = 0;
        rstn <= 1'b1;
        // Longest program is under 40 cycles; the self jump holds state after
        repeat (80) @(posedge clk_sys);
        #1;
    endtask

    task automatic ext_and_modes_test();
        clear_mem();
        dmem_b[8'h20] = 8'h85;
        dmem_b[8'h22] = 8'h01;
        dmem_b[8'h23] = 8'h80;
        {dmem_b[8'h33], dmem_b[8'h32], dmem_b[8'h31], dmem_b[8'h30]} = 32'h12345678;
        dmem_b[8'h34] = 8'hbc;
        dmem_b[8'h35] = 8'h9a;
        prog_q = {16'h1180, 16'h21ff, 16'h1000, 16'h5880, 16'h5cff, 16'h1220, 16'h6321,
                  16'h1424, 16'h6546, 16'h9607, 16'h890e, 16'h1880, 16'h7819, 16'h7809,
                  16'h7829, 16'h7839, 16'h7849, 16'h7859, 16'h7869, 16'h7899, 16'h7812,
                  16'h7809, 16'h7804, 16'h1a60, 16'h7a88, 16'h6b24, 16'h6ca9, 16'h74c6};
        run_prog();
        check("add_imm_sext", word_at(8'h80), 32'hffffff7f);
        check("logic_imm_zext", word_at(8'h84), 32'h0000007f);
        check("post_inc_byte", word_at(8'h88), 32'h00000021);
        check("byte_load_sext", word_at(8'h8c), 32'hffffff85);
        check("pre_dec_word", word_at(8'h90), 32'h00000022);
        check("word_load_sext", word_at(8'h94), 32'hffff8001);
        check("long_literal", word_at(8'h98), 32'h12345678);
        check("word_lit_and_pre_dec_byte", word_at(8'h9c), 32'h7fff9abc);
        check("misaligned_dropped", word_at(8'ha0), 32'h00000000);
        check("base_kept_on_error", word_at(8'h60), 32'hffffff9f);
        check("addr_err_count", n_err, 32'd3);
        check("pre_dec_word_store", word_at(8'h20), 32'h8001ff9f);
    endtask

    task automatic branch_test();
        clear_mem();
        prog_q = {16'h1800, 16'h1b00, 16'h1c00, 16'h1701, 16'h3701, 16'h4770, 16'hb000,
                  16'h1811, 16'h3701, 16'hbc01, 16'h1c55, 16'h1b44, 16'ha001, 16'h1a33,
                  16'h1b66, 16'h1040, 16'h7089, 16'h70a9, 16'h70b9, 16'h70c9, 16'h7079,
                  16'h10ff, 16'h54f0, 16'h1b58, 16'h7b09};
        run_prog();
        check("normal_jump_skips", word_at(8'h40), 32'h00000000);
        check("jump_slot_runs", word_at(8'h44), 32'h00000033);
        check("jump_target_skip", word_at(8'h48), 32'h00000000);
        check("cond_slot_runs", word_at(8'h4c), 32'h00000055);
        check("reg_add_result", word_at(8'h50), 32'h00000002);
        check("and_imm_zext", word_at(8'h58), 32'h000000f0);
        check("flag_after_cmp", {31'h0, cmp_flag}, 32'h0);
        check("no_addr_err", n_err, 32'd0);
    endtask

    task automatic bit_ops_test();
        clear_mem();
        dmem_b[8'h10] = 8'ha5;
        dmem_b[8'h11] = 8'h77;
        prog_q = {16'h1010, 16'hc80a, 16'hc43c, 16'hccff, 16'hc02c};
        run_prog();
        check("bit_rmw_byte", {24'h0, dmem_b[8'h10]}, 32'h000000d3);
        check("bit_neighbour", {24'h0, dmem_b[8'h11]}, 32'h00000077);
        check("bit_test_flag", {31'h0, cmp_flag}, 32'h1);
        check("retire_count", n_ret, 32'd72);
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        n_err = 0;
        ext_and_modes_test();
        branch_test();
        bit_ops_test();
        finish_test();
    end

    // Three programs take about 300 cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end
endmodule // cpu_operand_and_branch_semantics_test
